// [backlight_cfg_monitor.sv]
// assertions on the backlight configuration block
// assumes binding to the top module, seeing its ports only
`timescale 1ns/1ps
module backlight_cfg_monitor
(
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic [5:0] sink_pwm,
    input wire logic       switch_tick,
    input wire logic [5:0] boost_target_level,
    input wire logic       slew_stage_two_on,
    input wire logic       slew_stage_three_on
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [2:0] lay_r;
    // layout as last written
    always_ff @(posedge clk)
        if (!rst_b)
            lay_r <= 3'h0;
        else if (reg_wr_en && reg_addr == 8'hA5)
            lay_r <= reg_wr_data[6:4];
    a_level_follow: assert property (reg_wr_en && reg_addr == 8'hA6 |=>
        boost_target_level == $past(reg_wr_data[5:0])) else $error("level not taken");
    a_level_hold: assert property (!(reg_wr_en && reg_addr == 8'hA6) |=>
        $stable(boost_target_level)) else $error("level changed");
    a_stage_three: assert property (reg_wr_en && reg_addr == 8'hA7 |=>
        slew_stage_three_on == $past(reg_wr_data[5])) else $error("stage three wrong");
    a_stage_two: assert property (reg_wr_en && reg_addr == 8'hA7 |=>
        slew_stage_two_on == $past(reg_wr_data[4])) else $error("stage two wrong");
    a_tick_pulse: assert property (switch_tick |=> !switch_tick)
        else $error("tick too long");
    a_off_reserved: assert property (lay_r == 3'h7 && $past(lay_r, 2) == 3'h7 |->
        sink_pwm == 6'h00) else $error("sink on in reserved layout");
    a_off_two: assert property (lay_r == 3'h4 && $past(lay_r, 2) == 3'h4 |->
        sink_pwm[5:2] == 4'h0) else $error("sink on in two-phase layout");
    a_off_five: assert property (lay_r == 3'h1 && $past(lay_r, 2) == 3'h1 |->
        !sink_pwm[5]) else $error("sixth sink on");
    a_off_three: assert property (lay_r == 3'h3 && $past(lay_r, 2) == 3'h3 |->
        sink_pwm[5:3] == 3'h0) else $error("sink on in three-phase layout");
endmodule // backlight_cfg_monitor
bind backlight_pwm_boost_config backlight_cfg_monitor u_mon (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .sink_pwm(sink_pwm), .switch_tick(switch_tick), .boost_target_level(boost_target_level),
    .slew_stage_two_on(slew_stage_two_on), .slew_stage_three_on(slew_stage_three_on));

// [backlight_cfg_pkg.sv]
// constants, tables and state carriers for the backlight pwm and boost configuration block
// assumes a 250 MHz clock and a byte-wide register port on the same clock
package backlight_cfg_pkg;

    localparam int unsigned CLK_HZ = 250_000_000;

    // register offsets and reset values
    localparam logic [7:0] DIM_CFG_ADDR   = 8'hA5;
    localparam logic [7:0] BOOST_CFG_ADDR = 8'hA6;
    localparam logic [7:0] DRIVE_CFG_ADDR = 8'hA7;
    localparam logic [7:0] DIM_CFG_RST    = 8'h00;
    localparam logic [7:0] BOOST_CFG_RST  = 8'h00;
    localparam logic [5:0] DRIVE_CFG_RST  = 6'h00;

    // field positions
    localparam int LAYOUT_LSB    = 4;
    localparam int LAYOUT_MSB    = 6;
    localparam int DIM_RATE_LSB  = 0;
    localparam int DIM_RATE_MSB  = 3;
    localparam int SW_RATE_LSB   = 6;
    localparam int SW_RATE_MSB   = 7;
    localparam int LEVEL_LSB     = 0;
    localparam int LEVEL_MSB     = 5;
    localparam int STAGE3_BIT    = 5;
    localparam int STAGE2_BIT    = 4;
    localparam int CAP_LSB       = 0;
    localparam int CAP_MSB       = 1;

    // phase offsets in degrees per layout code and sink; 360 marks a sink held off
    localparam int DEG_OFF = 360;
    localparam int PHASE_DEG [8][6] = '{
        '{0, 60, 120, 180, 240, 320},
        '{0, 72, 144, 216, 288, 360},
        '{0, 90, 180, 270, 360, 360},
        '{0, 120, 240, 360, 360, 360},
        '{0, 180, 360, 360, 360, 360},
        '{0, 0, 120, 120, 240, 240},
        '{0, 0, 0, 180, 180, 180},
        '{360, 360, 360, 360, 360, 360}
    };

    // dimming rate is a multiple of 1202 Hz: 4808 Hz is 4, 38464 Hz is 32
    localparam int unsigned DIM_BASE_HZ = 1202;
    localparam int DIM_MULT [16] = '{4, 5, 6, 7, 8, 10, 11, 12, 13, 14, 15, 16, 20, 24, 28, 32};
    localparam int DIM_RES  [16] = '{10, 10, 10, 10, 10, 9, 9, 9, 9, 9, 9, 9, 8, 8, 8, 8};
    localparam int DUTY_W = 10;
    // cycles per degree of one 1202 Hz period
    localparam int unsigned PHASE_STEP_DEFAULT = CLK_HZ / (DIM_BASE_HZ * 360);
    localparam int ACC_W = 18;

    // boost switching rates and their periods in clock cycles
    localparam int unsigned SW_RATE0_KHZ = 312;
    localparam int unsigned SW_RATE1_KHZ = 625;
    localparam int unsigned SW_RATE2_KHZ = 1250;
    localparam logic [9:0] SW_PERIOD0 = 10'(CLK_HZ / (SW_RATE0_KHZ * 1000));
    localparam logic [9:0] SW_PERIOD1 = 10'(CLK_HZ / (SW_RATE1_KHZ * 1000));
    localparam logic [9:0] SW_PERIOD2 = 10'(CLK_HZ / (SW_RATE2_KHZ * 1000));

    typedef struct packed {
        logic [9:0] cnt;
        logic       tick;
    } switch_tick_state_s;

    typedef struct packed {
        logic [7:0]       dim_cfg;
        logic [7:0]       boost_cfg;
        logic [5:0]       drive_cfg;
        logic [7:0]       rd_data;
        logic [ACC_W-1:0] acc;
        logic [ACC_W-1:0] thr;
        logic [5:0]       sink;
        logic [2:0]       pin_meta;
        logic [2:0]       pin_sync;
    } backlight_state_s;

endpackage

// [backlight_pwm_boost_config.sv]
// backlight configuration registers, phase-shifted dimming pwm and boost settings
// assumes register port and duty level on clk; strap pins are asynchronous
`timescale 1ns/1ps
module backlight_pwm_boost_config
#(
    parameter int unsigned PHASE_STEP_CYCLES = backlight_cfg_pkg::PHASE_STEP_DEFAULT
)
(
    input  wire logic                                 clk,
    input  wire logic                                 rst_b,
    input  wire logic [7:0]                           reg_addr,
    input  wire logic                                 reg_wr_en,
    input  wire logic [7:0]                           reg_wr_data,
    input  wire logic                                 reg_rd_en,
    output logic [7:0]                                reg_rd_data,
    input  wire logic [backlight_cfg_pkg::DUTY_W-1:0] duty_level,
    input  wire logic                                 resistor_rate_enable,
    input  wire logic [1:0]                           resistor_rate_code,
    output logic [5:0]                                sink_pwm,
    output logic                                      switch_tick,
    output logic [5:0]                                boost_target_level,
    output logic                                      slew_stage_two_on,
    output logic                                      slew_stage_three_on,
    output logic [1:0]                                switch_current_cap
);
    import backlight_cfg_pkg::*;

    localparam logic [ACC_W:0] PERIOD_W = (ACC_W + 1)'(360 * PHASE_STEP_CYCLES);
    localparam logic [ACC_W:0] STEP_W   = (ACC_W + 1)'(PHASE_STEP_CYCLES);

    backlight_state_s    s_r;
    backlight_state_s    s_nxt;
    logic [2:0]          phase_layout_select;
    logic [3:0]          dimming_rate_select;
    logic [1:0]          switch_rate_select;
    logic                hit_dim;
    logic                hit_boost;
    logic                hit_drive;
    logic                wr_dim;
    logic                wr_boost;
    logic                wr_drive;
    logic [7:0]          rd_value;
    logic [5:0]          step;
    logic [ACC_W:0]      acc_sum;
    logic [ACC_W-1:0]    acc_next;
    int                  res;
    logic [DUTY_W-1:0]   duty_q;
    logic [27:0]         prod;
    logic [ACC_W-1:0]    thr_next;
    wire logic [5:0]     sink_hit;

    assign phase_layout_select = s_r.dim_cfg[LAYOUT_MSB:LAYOUT_LSB];
    assign dimming_rate_select = s_r.dim_cfg[DIM_RATE_MSB:DIM_RATE_LSB];

    // strap selects the externally set rate over the register field
    assign switch_rate_select = s_r.pin_sync[2] ? s_r.pin_sync[1:0]
                                                : s_r.boost_cfg[SW_RATE_MSB:SW_RATE_LSB];

    // register address decode
    assign hit_dim   = (reg_addr == DIM_CFG_ADDR);
    assign hit_boost = (reg_addr == BOOST_CFG_ADDR);
    assign hit_drive = (reg_addr == DRIVE_CFG_ADDR);

    // write strobes; unmapped addresses match none
    assign wr_dim   = reg_wr_en && hit_dim;
    assign wr_boost = reg_wr_en && hit_boost;
    assign wr_drive = reg_wr_en && hit_drive;

    // read mux; unmapped addresses read as zero
    always_comb
    begin
        rd_value = 8'h00;
        if (hit_dim)
        begin
            rd_value = s_r.dim_cfg;
        end
        else if (hit_boost)
        begin
            rd_value = s_r.boost_cfg;
        end
        else if (hit_drive)
        begin
            // drive bits 7:6 read back as zero
            rd_value = {2'b00, s_r.drive_cfg};
        end
    end

    // period accumulator advances by the rate multiple each clock
    always_comb
    begin
        step    = 6'(DIM_MULT[dimming_rate_select]);
        acc_sum = {1'b0, s_r.acc} + (ACC_W + 1)'(step);
        if (acc_sum >= PERIOD_W)
        begin
            acc_sum = acc_sum - PERIOD_W;
        end
        acc_next = acc_sum[ACC_W-1:0];
    end

    // duty quantised to the resolution of the selected rate
    always_comb
    begin
        res      = DIM_RES[dimming_rate_select];
        duty_q   = (duty_level >> (DUTY_W - res)) << (DUTY_W - res);
        prod     = 28'(duty_q) * 28'(PERIOD_W);
        thr_next = prod[27:DUTY_W];
    end

    // per-sink phase offset and compare
    for (genvar g = 0; g < 6; g++)
    begin : g_sink
        logic [8:0]     deg;
        logic [ACC_W:0] offset;
        logic [ACC_W:0] diff;
        logic           hit;

        always_comb
        begin
            deg    = 9'(PHASE_DEG[phase_layout_select][g]);
            offset = (ACC_W + 1)'(deg) * STEP_W;
            diff   = '0;
            hit    = 1'b0;
            if (deg == 9'(DEG_OFF))
            begin
                hit = 1'b0;
            end
            else
            begin
                if ({1'b0, s_r.acc} >= offset)
                begin
                    diff = {1'b0, s_r.acc} - offset;
                end
                else
                begin
                    diff = {1'b0, s_r.acc} + PERIOD_W - offset;
                end
                hit = diff < {1'b0, s_r.thr};
            end
        end

        assign sink_hit[g] = hit;
    end

    always_comb
    begin
        s_nxt = s_r;

        // strap pins through two flops
        s_nxt.pin_meta = {resistor_rate_enable, resistor_rate_code};
        s_nxt.pin_sync = s_r.pin_meta;

        // register writes
        if (wr_dim)
        begin
            s_nxt.dim_cfg = {1'b0, reg_wr_data[6:0]};
        end
        if (wr_boost)
        begin
            s_nxt.boost_cfg = reg_wr_data;
        end
        if (wr_drive)
        begin
            s_nxt.drive_cfg = reg_wr_data[5:0];
        end

        // register reads, one cycle latency; same-cycle write reads old value
        if (reg_rd_en)
        begin
            s_nxt.rd_data = rd_value;
        end

        // sinks registered, one clock behind the accumulator
        s_nxt.acc  = acc_next;
        s_nxt.thr  = thr_next;
        s_nxt.sink = sink_hit;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            s_r <= '0;
            s_r.dim_cfg <= DIM_CFG_RST;
            s_r.boost_cfg <= BOOST_CFG_RST;
            s_r.drive_cfg <= DRIVE_CFG_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    switch_tick_gen u_switch_tick
    (
        .clk       (clk),
        .rst_b     (rst_b),
        .rate_code (switch_rate_select),
        .tick      (switch_tick)
    );

    assign reg_rd_data         = s_r.rd_data;
    assign sink_pwm            = s_r.sink;
    assign boost_target_level  = s_r.boost_cfg[LEVEL_MSB:LEVEL_LSB];
    assign slew_stage_three_on = s_r.drive_cfg[STAGE3_BIT];
    assign slew_stage_two_on   = s_r.drive_cfg[STAGE2_BIT];
    assign switch_current_cap  = s_r.drive_cfg[CAP_MSB:CAP_LSB];

endmodule // backlight_pwm_boost_config

// [switch_tick_gen.sv]
// boost switching tick generator: one pulse per switching period
// assumes rate code from the same clock domain
`timescale 1ns/1ps
module switch_tick_gen
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [1:0] rate_code,
    output logic            tick
);
    import backlight_cfg_pkg::*;

    switch_tick_state_s s_r;
    switch_tick_state_s s_nxt;
    logic [9:0]         limit;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        limit = SW_PERIOD0;
        unique case (rate_code)
            2'h0: limit = SW_PERIOD0;
            2'h1: limit = SW_PERIOD1;
            2'h2: limit = SW_PERIOD2;
            2'h3: limit = 10'h000;
        endcase
        if (limit == 10'h000)
        begin
            s_nxt.cnt = 10'h000;
        end
        else if (s_r.cnt >= limit - 10'h001)
        begin
            s_nxt.cnt = 10'h000;
            s_nxt.tick = 1'b1;
        end
        else
        begin
            s_nxt.cnt = s_r.cnt + 10'h001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;

endmodule // switch_tick_gen

// [tb_backlight_pwm_boost_config.sv]
// self-checking bench for the backlight configuration block
// assumes a 250 MHz clock and a phase step of 2 cycles per degree
`timescale 1ns/1ps
module tb_backlight_pwm_boost_config;
    import backlight_cfg_pkg::*;
    localparam int M = 720;
    logic clk = 0, rst_b = 0, wr = 0, rd = 0, strap_en = 0, tick, s2, s3;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [9:0] duty = 10'h000;
    logic [1:0] strap = 2'h0, cap;
    logic [5:0] sink, level;
    int n_errors = 0, samples_checked = 0, cyc = 0;
    backlight_pwm_boost_config #(.PHASE_STEP_CYCLES(2)) DUT (.clk(clk), .rst_b(rst_b),
        .reg_addr(addr), .reg_wr_en(wr), .reg_wr_data(wdata), .reg_rd_en(rd),
        .reg_rd_data(rdata), .duty_level(duty), .resistor_rate_enable(strap_en),
        .resistor_rate_code(strap), .sink_pwm(sink), .switch_tick(tick),
        .boost_target_level(level), .slew_stage_two_on(s2), .slew_stage_three_on(s3),
        .switch_current_cap(cap));
    initial forever #2 clk = ~clk;
    task final_report;
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_errors++;
            final_report;
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task wreg(input logic [7:0] a, input logic [7:0] d);
        addr = a; wdata = d; wr = 1;
        @(posedge clk); #1 wr = 0;
        @(posedge clk); #1;
    endtask
    task rchk(input logic [7:0] a, input logic [7:0] e);
        addr = a; rd = 1;
        @(posedge clk); #1 rd = 0;
        chk("read", e, rdata);
        @(posedge clk); #1;
    endtask
    // cycles between rising edges of sink 0 or of the tick
    task gap(input logic which, input int e);
        int t0, n;
        logic p, s;
        t0 = -1; n = -1; p = 1;
        repeat (400) @(posedge clk);
        for (int i = 0; i < 1800 && n < 0; i++)
        begin
            @(posedge clk); #1;
            s = which ? tick : sink[0];
            if (s && !p)
            begin
                if (t0 >= 0) n = i - t0;
                t0 = i;
            end
            p = s;
        end
        chk("period", e, n);
    endtask
    // active sinks and phase relations of one layout
    task lay(input logic [2:0] code, input logic [9:0] d, input logic [5:0] mask);
        logic [5:0] seen;
        logic bad;
        duty = d; seen = 0; bad = 0;
        wreg({1'b0, code, 4'h0}, 8'h00);
        wreg(8'hA5, {1'b0, code, 4'h0});
        repeat (10) @(posedge clk);
        for (int i = 0; i < 200; i++)
        begin
            @(posedge clk); #1;
            seen |= sink;
            if (code == 4 && sink[1] === sink[0]) bad = 1;
            if (code == 5 && (sink[0] !== sink[1] || sink[4] !== sink[5])) bad = 1;
            if (code == 6 && (sink[0] === sink[3] || sink[1:0] !== {2{sink[2]}})) bad = 1;
            if (d[9] && code == 0 && sink[3] === sink[0]) bad = 1;
            if (d[9] && code == 2 && sink[2] === sink[0]) bad = 1;
        end
        chk("active sinks", mask, seen);
        chk("phase", 0, bad);
    endtask
    task reg_access;
        rchk(8'hA6, 8'h00);
        wreg(8'hA5, 8'hFF);
        rchk(8'hA5, 8'h7F);
        wreg(8'hA6, 8'h3F);
        chk("level", 8'h3F, level);
        rchk(8'hA6, 8'h3F);
        wreg(8'hA7, 8'h10);
        chk("stages", 2'h1, {s3, s2});
        wreg(8'hA7, 8'hFF);
        chk("stages", 2'h3, {s3, s2});
        chk("cap", 2'h3, cap);
        rchk(8'hA7, 8'h3F);
        wreg(8'hA8, 8'hFF);
        rchk(8'hA8, 8'h00);
    endtask
    // reset in mid-run clears registers and outputs
    task reset_mid;
        wreg(8'hA6, 8'h55);
        rchk(8'hA6, 8'h55);
        rst_b = 0;
        repeat (3) @(posedge clk);
        #1 rst_b = 1;
        chk("reset read", 8'h00, rdata);
        chk("reset level", 6'h00, level);
        chk("reset drive", 4'h0, {s3, s2, cap});
        chk("reset sinks", 6'h00, sink);
        chk("reset tick", 1'b0, tick);
        rchk(8'hA6, 8'h00);
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        #1 rst_b = 1;
        reg_access;
        lay(3'h0, 10'h200, 6'h3F);
        lay(3'h1, 10'h200, 6'h1F);
        lay(3'h2, 10'h200, 6'h0F);
        lay(3'h3, 10'h200, 6'h07);
        lay(3'h4, 10'h200, 6'h03);
        lay(3'h5, 10'h200, 6'h3F);
        lay(3'h6, 10'h200, 6'h3F);
        lay(3'h7, 10'h200, 6'h00);
        lay(3'h0, 10'h000, 6'h00);
        duty = 10'h200;
        wreg(8'hA5, 8'h04); gap(0, M / 8);
        wreg(8'hA5, 8'h05); gap(0, M / 10);
        wreg(8'hA5, 8'h0C); gap(0, M / 20);
        wreg(8'hA6, 8'h80); gap(1, 200);
        wreg(8'hA6, 8'h40); gap(1, 400);
        wreg(8'hA6, 8'h00); gap(1, 801);
        wreg(8'hA6, 8'hC0); gap(1, -1);
        strap_en = 1; strap = 2'h2; gap(1, 200);
        reset_mid;
        final_report;
    end
endmodule // tb_backlight_pwm_boost_config
